// file: ivf_pkg.sv
`default_nettype none
// ==========================================================
// Command codes, field layout, reset values and types
package ivf_pkg;

  localparam logic [7:0] CMD_VIN_OV_WARN = 8'h57;
  localparam logic [7:0] CMD_VIN_UV_WARN = 8'h58;
  localparam logic [7:0] CMD_VIN_UV_FAULT = 8'h59;
  localparam logic [7:0] CMD_VIN_UV_RESP = 8'h5a;

  localparam logic [15:0] OV_WARN_RST = 16'h0000;
  localparam logic [15:0] UV_WARN_RST = 16'h0000;
  localparam logic [15:0] UV_FAULT_RST = 16'h0000;
  localparam logic [7:0] UV_RESP_RST = 8'h80;

  localparam int RESP_MSB = 7;
  localparam int RESP_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;

  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_ENDLESS = 3'h7;

  // Linear word: 5-bit signed exponent above an 11-bit signed mantissa
  localparam int LIN_EXP_MSB = 15;
  localparam int LIN_MANT_MSB = 10;
  localparam int FIX_W = 48;

  localparam int CLK_PERIOD_NS = 50;

  typedef enum logic [1:0] {
    RESP_IGNORE = 2'b00,
    RESP_DELAY = 2'b01,
    RESP_DISABLE = 2'b10,
    RESP_LATCH = 2'b11
  } ivf_resp_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_DELAY = 2'b01,
    ST_RETRY = 2'b10,
    ST_LATCH = 2'b11
  } ivf_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [15:0] data;
  } ivf_cmd_t;

  typedef struct packed {
    logic ov_warn;
    logic uv_warn;
    logic uv_fault;
  } ivf_flags_t;

  // Scale a linear word to a fixed-point value with 16 fraction bits
  function automatic logic signed [FIX_W-1:0] ivf_lin_to_fix(input logic [15:0] w);
    logic signed [FIX_W-1:0] mant;
    logic [4:0] shift;
    mant = FIX_W'(signed'(w[LIN_MANT_MSB:0]));
    // Flipping the exponent sign bit gives exponent plus 16
    shift = {~w[LIN_EXP_MSB], w[LIN_EXP_MSB-1:LIN_MANT_MSB+1]};
    return mant <<< shift;
  endfunction

endpackage
`default_nettype wire

// file: ivf_unit_timer.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Counts 2^n time units, each unit_cycles_i clocks long
module ivf_unit_timer #(
  parameter int UNIT_W = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic [UNIT_W-1:0] unit_cycles_i,
  input wire logic [2:0] units_exp_i,
  output logic busy_o,
  output logic done_o
);

  logic [UNIT_W-1:0] pre_reg;
  logic [7:0] units_reg;
  logic [7:0] units_last_reg;
  logic busy_reg;
  logic done_reg;

  // A unit length of zero is taken as one clock
  wire pre_last = (pre_reg + UNIT_W'(1) >= unit_cycles_i);
  wire units_last = (units_reg == units_last_reg);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || stop_i) begin
      pre_reg <= '0;
      units_reg <= 8'h00;
      units_last_reg <= 8'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (start_i) begin
      pre_reg <= '0;
      units_reg <= 8'h00;
      units_last_reg <= 8'((9'h001 << units_exp_i) - 9'h001);
      busy_reg <= 1'b1;
      done_reg <= 1'b0;
    end else begin
      done_reg <= busy_reg && pre_last && units_last;
      if (busy_reg) begin
        pre_reg <= pre_last ? '0 : pre_reg + UNIT_W'(1);
        if (pre_last) begin
          units_reg <= units_reg + 8'h01;
          busy_reg <= !units_last;
        end
      end
    end
  end

  assign busy_o = busy_reg;
  assign done_o = done_reg;

endmodule
`default_nettype wire

// file: ivf_fault_handler.sv
// Functional notes
// - Command 0x57 is a read/write word holding the input over-voltage warning limit in linear volts.
// - Command 0x58 is a read/write word holding the input under-voltage warning limit in linear format.
// - Command 0x59 is a read/write word holding the input under-voltage fault limit in linear volts.
// - Command 0x5a is a read/write byte with response, retry-count and delay fields for the under-voltage fault.
// - Response 00 keeps the converter running untouched while the fault is present.
// - Response 01 runs on for the programmed delay and, if the fault remains, then acts on the retry count.
// - Response 10 disables the output at once and then follows the retry count.
// - Response 11 holds the output off until the status bit is cleared, a clear-all arrives or reset is applied.
// - An off-then-on command sequence from the pin, the operation command or both also clears the fault.
// - Retry code 000 makes no restart attempt and keeps the output off until the fault is cleared.
// - Retry codes 001 to 100 attempt that many restarts and then stay off until the fault is cleared.
// - Successive restart attempts start one programmed delay apart.
// - Retry codes 101 and 110 attempt five and six restarts and then stay off until the fault is cleared.
// - Retry code 111 retries without limit until commanded off, reset, or shut down by another fault.
// - Delay code n stands for 2^n time units, the unit length being supplied from outside.
`timescale 1ns/1ps
`default_nettype none
module ivf_fault_handler import ivf_pkg::*; #(
  parameter int UNIT_W = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire ivf_cmd_t cmd_i,
  output logic cmd_ack_o,
  output logic [15:0] rd_data_o,
  input wire logic meas_valid_i,
  input wire logic [15:0] meas_vin_i,
  input wire logic [UNIT_W-1:0] unit_cycles_i,
  input wire logic run_cmd_i,
  input wire logic other_fault_i,
  input wire ivf_flags_t flag_clear_i,
  input wire logic clear_faults_i,
  output ivf_flags_t flags_o,
  output logic out_enable_o,
  output logic restart_o,
  output logic retrying_o,
  output logic latched_o
);

  // ==========================================================
  // Limit and response registers
  logic [15:0] ov_warn_reg;
  logic [15:0] uv_warn_reg;
  logic [15:0] uv_fault_reg;
  logic [7:0] uv_resp_reg;
  logic [15:0] rd_data_reg;

  wire hit_ov = (cmd_i.code == CMD_VIN_OV_WARN);
  wire hit_uvw = (cmd_i.code == CMD_VIN_UV_WARN);
  wire hit_uvf = (cmd_i.code == CMD_VIN_UV_FAULT);
  wire hit_resp = (cmd_i.code == CMD_VIN_UV_RESP);
  wire hit_any = hit_ov | hit_uvw | hit_uvf | hit_resp;

  // Unknown codes are not acknowledged and read back as zero
  assign cmd_ack_o = (cmd_i.wr | cmd_i.rd) & hit_any;

  wire [15:0] rd_sel = hit_ov ? ov_warn_reg :
                       hit_uvw ? uv_warn_reg :
                       hit_uvf ? uv_fault_reg :
                       hit_resp ? {8'h00, uv_resp_reg} : 16'h0000;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ov_warn_reg <= OV_WARN_RST;
      uv_warn_reg <= UV_WARN_RST;
      uv_fault_reg <= UV_FAULT_RST;
      uv_resp_reg <= UV_RESP_RST;
      rd_data_reg <= 16'h0000;
    end else begin
      if (cmd_i.wr && hit_ov) ov_warn_reg <= cmd_i.data;
      if (cmd_i.wr && hit_uvw) uv_warn_reg <= cmd_i.data;
      if (cmd_i.wr && hit_uvf) uv_fault_reg <= cmd_i.data;
      if (cmd_i.wr && hit_resp) uv_resp_reg <= cmd_i.data[7:0];
      if (cmd_i.rd) rd_data_reg <= rd_sel;
    end
  end

  assign rd_data_o = rd_data_reg;

  wire ivf_resp_t resp_sel = ivf_resp_t'(uv_resp_reg[RESP_MSB:RESP_LSB]);
  wire [2:0] retry_sel = uv_resp_reg[RETRY_MSB:RETRY_LSB];
  wire [2:0] delay_sel = uv_resp_reg[DELAY_MSB:DELAY_LSB];

  // ==========================================================
  // Threshold comparison
  wire signed [FIX_W-1:0] meas_fix = ivf_lin_to_fix(meas_vin_i);
  wire signed [FIX_W-1:0] ov_fix = ivf_lin_to_fix(ov_warn_reg);
  wire signed [FIX_W-1:0] uvw_fix = ivf_lin_to_fix(uv_warn_reg);
  wire signed [FIX_W-1:0] uvf_fix = ivf_lin_to_fix(uv_fault_reg);

  wire above_ov = meas_fix > ov_fix;
  wire below_uvw = meas_fix < uvw_fix;
  wire below_uvf = meas_fix < uvf_fix;

  ivf_flags_t flags_reg;
  ivf_flags_t flags_next;
  logic uv_present_reg;

  // A set in the same cycle as a clear wins, so no crossing is lost
  always_comb begin
    flags_next.ov_warn = (meas_valid_i & above_ov) |
                         (flags_reg.ov_warn & ~(flag_clear_i.ov_warn | clear_faults_i));
    flags_next.uv_warn = (meas_valid_i & below_uvw) |
                         (flags_reg.uv_warn & ~(flag_clear_i.uv_warn | clear_faults_i));
    flags_next.uv_fault = (meas_valid_i & below_uvf) |
                          (flags_reg.uv_fault & ~(flag_clear_i.uv_fault | clear_faults_i));
  end

  // The fault level follows the latest sample; decisions use a fresh one at once
  wire uv_now = meas_valid_i ? below_uvf : uv_present_reg;

  // ==========================================================
  // Run command edges
  logic run_reg;
  wire run_fall = run_reg & ~run_cmd_i;
  wire run_rise = ~run_reg & run_cmd_i;
  wire clear_evt = flag_clear_i.uv_fault | clear_faults_i | run_rise;

  // ==========================================================
  // Fault response state machine
  ivf_state_t state_reg;
  ivf_state_t state_next;
  logic [2:0] attempts_reg;
  logic [2:0] attempts_next;
  logic restart_reg;
  logic restart_next;
  logic timer_start;
  logic timer_busy;
  logic timer_done;

  wire uv_trip = meas_valid_i & below_uvf & run_reg;
  wire no_retry = (retry_sel == RETRY_NONE);
  wire [2:0] attempts_inc = attempts_reg + 3'h1;
  // Code 7 never runs out; codes 1 to 6 give that many attempts
  wire last_try = (retry_sel != RETRY_ENDLESS) && (attempts_inc >= retry_sel);

  always_comb begin
    state_next = state_reg;
    attempts_next = attempts_reg;
    restart_next = 1'b0;
    timer_start = 1'b0;
    case (state_reg)
      ST_RUN: begin
        if (uv_trip) begin
          case (resp_sel)
            RESP_DELAY: begin
              state_next = ST_DELAY;
              timer_start = 1'b1;
            end
            RESP_DISABLE: begin
              state_next = no_retry ? ST_LATCH : ST_RETRY;
              timer_start = !no_retry;
              attempts_next = 3'h0;
            end
            RESP_LATCH: begin
              state_next = ST_LATCH;
            end
            default: begin
              state_next = ST_RUN;
            end
          endcase
        end
      end
      ST_DELAY: begin
        if (timer_done) begin
          if (uv_now) begin
            state_next = no_retry ? ST_LATCH : ST_RETRY;
            timer_start = !no_retry;
            attempts_next = 3'h0;
          end else begin
            state_next = ST_RUN;
          end
        end
      end
      ST_RETRY: begin
        if (other_fault_i) begin
          state_next = ST_LATCH;
        end else if (timer_done) begin
          restart_next = 1'b1;
          if (!uv_now) begin
            state_next = ST_RUN;
          end else if (last_try) begin
            state_next = ST_LATCH;
          end else begin
            attempts_next = attempts_inc;
            timer_start = 1'b1;
          end
        end
      end
      ST_LATCH: begin
        if (clear_evt) state_next = ST_RUN;
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
    // Commanded off ends any response in progress
    if (run_fall) begin
      state_next = ST_RUN;
      timer_start = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_RUN;
      attempts_reg <= 3'h0;
      restart_reg <= 1'b0;
      run_reg <= 1'b0;
      flags_reg <= '0;
      uv_present_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      attempts_reg <= attempts_next;
      restart_reg <= restart_next;
      run_reg <= run_cmd_i;
      flags_reg <= flags_next;
      uv_present_reg <= uv_now;
    end
  end

  // ==========================================================
  // Delay and retry timer
  ivf_unit_timer #(
    .UNIT_W(UNIT_W)
  ) u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .start_i(timer_start),
    .stop_i(run_fall),
    .unit_cycles_i(unit_cycles_i),
    .units_exp_i(delay_sel),
    .busy_o(timer_busy),
    .done_o(timer_done)
  );

  // Output stays on through an ignored fault and the run-on delay
  assign out_enable_o = run_reg && ((state_reg == ST_RUN) || (state_reg == ST_DELAY));
  assign restart_o = restart_reg;
  assign retrying_o = (state_reg == ST_RETRY);
  assign latched_o = (state_reg == ST_LATCH);
  assign flags_o = flags_reg;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_ov_write;
    (cmd_i.wr && hit_ov) |=> (ov_warn_reg == $past(cmd_i.data));
  endproperty
  a_ov_write: assert property (p_ov_write) else $error("over-voltage warning limit not stored");

  property p_uvw_write;
    (cmd_i.wr && hit_uvw) |=> (uv_warn_reg == $past(cmd_i.data));
  endproperty
  a_uvw_write: assert property (p_uvw_write) else $error("under-voltage warning limit not stored");

  property p_uvf_readback;
    (cmd_i.rd && hit_uvf && !cmd_i.wr) |=> (rd_data_o == uv_fault_reg);
  endproperty
  a_uvf_readback: assert property (p_uvf_readback) else $error("fault limit read back wrong");

  property p_resp_byte;
    (cmd_i.wr && hit_resp) ##1 (cmd_i.rd && hit_resp && !cmd_i.wr) |=>
      (rd_data_o == {8'h00, $past(cmd_i.data[7:0], 2)});
  endproperty
  a_resp_byte: assert property (p_resp_byte) else $error("response byte read back wrong");

  property p_ignore;
    (state_reg == ST_RUN && resp_sel == RESP_IGNORE && run_reg && run_cmd_i) |=>
      (state_reg == ST_RUN && out_enable_o);
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignored fault disturbed the output");

  sequence s_trip(ivf_resp_t r);
    state_reg == ST_RUN && uv_trip && resp_sel == r && run_cmd_i;
  endsequence

  property p_delay_entry;
    s_trip(RESP_DELAY) |=> (state_reg == ST_DELAY && out_enable_o && timer_busy);
  endproperty
  a_delay_entry: assert property (p_delay_entry) else $error("run-on delay not entered");

  property p_disable_now;
    s_trip(RESP_DISABLE) |=> !out_enable_o;
  endproperty
  a_disable_now: assert property (p_disable_now) else $error("output not disabled on fault");

  property p_latch_holds;
    (state_reg == ST_LATCH && !clear_evt && !run_fall) |=> (state_reg == ST_LATCH && !out_enable_o);
  endproperty
  a_latch_holds: assert property (p_latch_holds) else $error("latched fault released early");

  property p_off_clears;
    run_fall |=> (state_reg == ST_RUN && !timer_busy);
  endproperty
  a_off_clears: assert property (p_off_clears) else $error("off command did not clear response");

  property p_no_retry;
    s_trip(RESP_DISABLE) and (retry_sel == RETRY_NONE) |=> (state_reg == ST_LATCH && !timer_busy && !restart_o);
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("restart made with retry code zero");

  sequence s_failed_try;
    state_reg == ST_RETRY && timer_done && uv_now && !other_fault_i && !run_fall;
  endsequence

  property p_retry_limit;
    s_failed_try and (retry_sel != RETRY_ENDLESS) and (attempts_reg + 3'h1 == retry_sel) |=>
      (state_reg == ST_LATCH && restart_o);
  endproperty
  a_retry_limit: assert property (p_retry_limit) else $error("retry limit not honoured");

  property p_retry_spacing;
    s_failed_try and !last_try |=> (state_reg == ST_RETRY && timer_busy) ##1 !timer_done;
  endproperty
  a_retry_spacing: assert property (p_retry_spacing) else $error("next attempt not spaced by delay");

  property p_retry_endless;
    s_failed_try and (retry_sel == RETRY_ENDLESS) |=> (state_reg == ST_RETRY && timer_busy);
  endproperty
  a_retry_endless: assert property (p_retry_endless) else $error("endless retry stopped");

  property p_flag_ov;
    (meas_valid_i && above_ov) |=> flags_o.ov_warn;
  endproperty
  a_flag_ov: assert property (p_flag_ov) else $error("over-voltage warning flag not raised");

  property p_flag_uvf;
    (meas_valid_i && below_uvf) |=> (flags_o.uv_fault && uv_present_reg);
  endproperty
  a_flag_uvf: assert property (p_flag_uvf) else $error("under-voltage fault flag not raised");

endmodule
`default_nettype wire

// file: ivf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host side: issues one-cycle register strobes from the falling edge
module ivf_host_model import ivf_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic cmd_ack_i,
  input wire logic [15:0] rd_data_i,
  output ivf_cmd_t cmd_o
);
  initial cmd_o = '0;

  // Idle fields carry inverted values so a stale code or word is never mistaken for a request
  task automatic wr_reg(input logic [7:0] code, input logic [15:0] data, output logic ack);
    @(negedge sys_clk_i);
    cmd_o = '{wr: 1'b1, rd: 1'b0, code: code, data: data};
    @(posedge sys_clk_i);
    ack = cmd_ack_i;
    @(negedge sys_clk_i);
    cmd_o = '{wr: 1'b0, rd: 1'b0, code: ~code, data: ~data};
  endtask

  task automatic rd_reg(input logic [7:0] code, output logic [15:0] data, output logic ack);
    @(negedge sys_clk_i);
    cmd_o = '{wr: 1'b0, rd: 1'b1, code: code, data: 16'h0000};
    @(posedge sys_clk_i);
    ack = cmd_ack_i;
    @(negedge sys_clk_i);
    cmd_o = '{wr: 1'b0, rd: 1'b0, code: ~code, data: 16'hffff};
    data = rd_data_i;
  endtask
endmodule
`default_nettype wire

// file: test_input_voltage_fault_handler.sv
`timescale 1ns/1ps
`default_nettype none
module test_input_voltage_fault_handler;
  import ivf_pkg::*;
  localparam int UNIT = 2;
  localparam int LIMIT = 20000;
  localparam logic [15:0] NORM = 16'h0030;
  localparam logic [15:0] LOW = 16'h0020;
  localparam logic [15:0] HIGH = 16'h0050;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  ivf_cmd_t cmd;
  logic cmd_ack, restart, retrying, latched, out_en;
  logic [15:0] rd_data;
  logic [15:0] meas_vin = NORM;
  logic run_cmd = 1'b1;
  logic meas_valid = 1'b1;
  logic other_fault = 1'b0;
  ivf_flags_t flag_clear = '0;
  logic clear_faults = 1'b0;
  ivf_flags_t flags;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;

  always #(CLK_PERIOD_NS / 2) sys_clk_i = ~sys_clk_i;

  ivf_host_model host (.sys_clk_i(sys_clk_i), .cmd_ack_i(cmd_ack), .rd_data_i(rd_data), .cmd_o(cmd));

  ivf_fault_handler #(.UNIT_W(16)) dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd), .cmd_ack_o(cmd_ack), .rd_data_o(rd_data),
    .meas_valid_i(meas_valid), .meas_vin_i(meas_vin), .unit_cycles_i(16'(UNIT)), .run_cmd_i(run_cmd),
    .other_fault_i(other_fault), .flag_clear_i(flag_clear), .clear_faults_i(clear_faults),
    .flags_o(flags), .out_enable_o(out_en), .restart_o(restart), .retrying_o(retrying),
    .latched_o(latched)
  );

  // ==========================================================
  // Helpers
  task automatic stop_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  task automatic vin(input logic [15:0] v);
    @(negedge sys_clk_i);
    meas_vin = v;
  endtask

  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    logic a;
    host.wr_reg(code, data, a);
    chk("write ack", 16'h0001, 16'(a));
  endtask

  task automatic set_resp(input logic [1:0] r, input logic [2:0] t, input logic [2:0] d);
    wr(CMD_VIN_UV_RESP, {8'h00, r, t, d});
  endtask

  task automatic pulse(input ivf_flags_t f, input logic all);
    @(negedge sys_clk_i);
    flag_clear = f;
    clear_faults = all;
    @(negedge sys_clk_i);
    flag_clear = '0;
    clear_faults = 1'b0;
  endtask

  task automatic toggle_run();
    @(negedge sys_clk_i);
    run_cmd = 1'b0;
    idle(2);
    run_cmd = 1'b1;
    idle(3);
  endtask

  // Voltage back to normal, all flags cleared, converter cycled off and on
  task automatic rearm();
    vin(NORM);
    pulse('0, 1'b1);
    toggle_run();
  endtask

  task automatic count_restarts(input int lim, input int gap, output int n, output logic ok);
    int last;
    n = 0;
    ok = 1'b1;
    last = -1;
    for (int i = 0; i < lim && latched !== 1'b1; i++) begin
      @(negedge sys_clk_i);
      if (out_en !== 1'b0 || (latched !== 1'b1 && retrying !== 1'b1)) ok = 1'b0;
      if (restart === 1'b1) begin
        if (last >= 0 && (i - last < gap || i - last > gap + 2)) ok = 1'b0;
        last = i;
        n++;
      end
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    logic [7:0] codes [3] = '{CMD_VIN_OV_WARN, CMD_VIN_UV_WARN, CMD_VIN_UV_FAULT};
    logic [15:0] vals [3] = '{16'h004b, 16'h0026, 16'h0024};
    logic [15:0] rsts [3] = '{OV_WARN_RST, UV_WARN_RST, UV_FAULT_RST};
    logic [15:0] d;
    logic a;
    for (int i = 0; i < 3; i++) begin
      host.rd_reg(codes[i], d, a);
      chk("limit reset", rsts[i], d);
      wr(codes[i], vals[i]);
      host.rd_reg(codes[i], d, a);
      chk("limit readback", vals[i], d);
      chk("read ack", 16'h0001, 16'(a));
    end
    host.rd_reg(CMD_VIN_UV_RESP, d, a);
    chk("action reset", {8'h00, UV_RESP_RST}, d);
    wr(CMD_VIN_UV_RESP, 16'hff3c);
    host.rd_reg(CMD_VIN_UV_RESP, d, a);
    chk("action byte", 16'h003c, d);
    host.wr_reg(8'h5b, 16'h1234, a);
    chk("unmapped ack", 16'h0000, 16'(a));
    host.rd_reg(8'h5b, d, a);
    chk("unmapped data", 16'h0000, d);
    chk("unmapped read ack", 16'h0000, 16'(a));
  endtask

  task automatic t_flags();
    set_resp(2'b00, 3'd0, 3'd0);
    rearm();
    meas_valid = 1'b0;
    vin(HIGH);
    idle(2);
    chk("flags unsampled", 16'h0000, 16'(flags));
    meas_valid = 1'b1;
    idle(2);
    chk("flags high", 16'h0004, 16'(flags));
    vin(NORM);
    pulse('{ov_warn: 1'b1, uv_warn: 1'b0, uv_fault: 1'b0}, 1'b0);
    chk("flags cleared", 16'h0000, 16'(flags));
    vin(16'h0025);
    idle(2);
    chk("flags warn", 16'h0002, 16'(flags));
    vin(LOW);
    for (int i = 0; i < 10; i++) begin
      @(negedge sys_clk_i);
      chk("ignore enable", 16'h0001, 16'(out_en));
    end
    chk("flags fault", 16'h0003, 16'(flags));
    vin(NORM);
    pulse('0, 1'b1);
    chk("flags clear all", 16'h0000, 16'(flags));
  endtask

  task automatic t_latch();
    set_resp(2'b11, 3'd0, 3'd0);
    for (int k = 0; k < 3; k++) begin
      vin(LOW);
      idle(3);
      vin(NORM);
      idle(5);
      chk("held off", 16'h0002, {14'h0, latched, out_en});
      if (k == 0) pulse('{ov_warn: 1'b0, uv_warn: 1'b0, uv_fault: 1'b1}, 1'b0);
      if (k == 1) pulse('0, 1'b1);
      if (k == 2) toggle_run();
      idle(2);
      chk("released", 16'h0001, {14'h0, latched, out_en});
    end
  endtask

  task automatic t_no_retry();
    set_resp(2'b10, 3'd0, 3'd0);
    rearm();
    vin(LOW);
    @(negedge sys_clk_i);
    chk("off at once", 16'h0000, 16'(out_en));
    for (int i = 0; i < 30 && latched !== 1'b1; i++) @(negedge sys_clk_i);
    chk("no retry latch", 16'h0002, {13'h0, retrying, latched, out_en});
  endtask

  task automatic t_retries();
    int n;
    logic ok;
    for (int code = 1; code <= 6; code++) begin
      set_resp(2'b10, 3'(code), 3'd1);
      rearm();
      vin(LOW);
      count_restarts(400, 2 * UNIT, n, ok);
      chk("attempts", 16'(code), 16'(n));
      chk("spacing and off", 16'h0001, 16'(ok));
      idle(20);
      chk("stays off", 16'h0002, {14'h0, latched, out_en});
    end
  endtask

  task automatic t_endless();
    int n;
    logic ok;
    set_resp(2'b10, 3'd7, 3'd0);
    rearm();
    vin(LOW);
    count_restarts(80, UNIT, n, ok);
    chk("endless", 16'h0001, {15'h0, n > 8 && latched === 1'b0});
    chk("endless spacing", 16'h0001, 16'(ok));
    @(negedge sys_clk_i);
    other_fault = 1'b1;
    idle(3);
    other_fault = 1'b0;
    chk("other fault stop", 16'h0001, 16'(latched));
  endtask

  task automatic t_delay();
    set_resp(2'b01, 3'd0, 3'd2);
    rearm();
    vin(LOW);
    for (int i = 0; i < 6; i++) begin
      @(negedge sys_clk_i);
      chk("runs on", 16'h0001, 16'(out_en));
    end
    vin(NORM);
    idle(10);
    chk("recovered", 16'h0001, {14'h0, latched, out_en});
    vin(LOW);
    idle(6);
    chk("delay runs on", 16'h0001, {14'h0, latched, out_en});
    idle(9);
    chk("delay then act", 16'h0002, {14'h0, latched, out_en});
  endtask

  // A reset in mid-run must drop a latched fault and restore the settings
  task automatic t_reset();
    logic [15:0] d;
    logic a;
    chk("latched before reset", 16'h0001, 16'(latched));
    @(negedge sys_clk_i);
    rst_n_i = 1'b0;
    idle(4);
    rst_n_i = 1'b1;
    @(negedge sys_clk_i);
    chk("reset clears latch", 16'h0001, {14'h0, latched, out_en});
    host.rd_reg(CMD_VIN_UV_RESP, d, a);
    chk("action after reset", {8'h00, UV_RESP_RST}, d);
  endtask

  initial begin
    idle(4);
    rst_n_i = 1'b1;
    t_regs();
    t_flags();
    t_latch();
    t_no_retry();
    t_retries();
    t_endless();
    t_delay();
    t_reset();
    stop_test();
  end
endmodule
`default_nettype wire
